// File: core/ssfd_core.v
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "ssfd_consts.vh"
// Notes on behaviour
// - receive-full sets when a finished byte enters the receive buffer; reset clears it.
// - receive-full requests an interrupt only with the receive interrupt enable set.
// - a data register read clears receive-full unless a new byte enters in the same cycle.
// - error interrupt enable gates overrun and mode-fault requests; reset clears it.
// - overrun sets when a byte arrives while the previous one is unread.
// - on overrun the old byte stays and the new byte is dropped.
// - overrun clears after a status read seeing it, then a data read.
// - slave: mode fault sets if slave select rises during a transfer.
// - master: mode fault sets whenever slave select is low.
// - mode fault clears after a status read seeing it, then a data write.
// - transmit-empty sets on a load into the shifter unless a data write lands in the same cycle; gated by its enable; reset sets it.
// - idle: written byte loads at once, transmit-empty sets within two cycles.
// - slave mid-transfer: load waits for transfer end, transmit-empty stays clear.
// - mode fault sets only with fault detect enable; clearing enable keeps the flag.
// - master without fault detect: slave select is general I/O, ignored by the block.
// - slave: slave select never general I/O; enable only masks mode fault.
// - master rate code 00/01/10/11 gives divisor 2/8/32/128; ignored as slave.
// - master serial clock is base clock over twice the divisor.
// - data writes go to transmit buffer, reads come from receive buffer.
// - transmit interrupt enable gates transmit-empty requests; reset clears it.
module ssfd_core
(
  input wire clk,
  input wire arst_n,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire shift_done,
  input wire [7:0] shift_rx_byte,
  input wire xfer_active,
  output reg shift_load,
  output reg [7:0] shift_tx_byte,
  output reg sck_half_tick,
  input wire ss_n_in,
  input wire gpio_ss_out,
  input wire gpio_ss_oe,
  output reg ss_n_out,
  output reg ss_n_oe,
  output reg ss_n_to_engine,
  output reg rx_irq_req,
  output reg tx_irq_req,
  output reg err_irq_req
);

  reg rx_irq_enable;
  reg master_mode;
  reg block_enable;
  reg tx_irq_enable;
  reg error_irq_enable;
  reg fault_detect_enable;
  reg rate_select_hi;
  reg rate_select_lo;
  reg receive_full_flag;
  reg overrun_flag;
  reg mode_fault_flag;
  reg transmit_empty_flag;
  reg [7:0] rx_buffer;
  reg [7:0] tx_buffer;
  reg ovr_armed;
  reg mode_fault_flag_armed;
  reg ss_n_prev;
  reg [7:0] rate_count;
  reg next_receive_full_flag;
  reg next_overrun_flag;
  reg next_ovr_armed;
  reg next_mode_fault_flag;
  reg next_mode_fault_flag_armed;
  reg next_transmit_empty_flag;
  reg next_rx_irq_req;
  reg next_tx_irq_req;
  reg next_err_irq_req;
  reg [7:0] next_reg_rdata;

  wire sel_ctl = reg_hit(reg_addr, `SSFD_OFF_CONTROL);
  wire sel_sc = reg_hit(reg_addr, `SSFD_OFF_STATUS_CONTROL);
  wire sel_data = reg_hit(reg_addr, `SSFD_OFF_DATA_BUFFER);
  wire data_rd = reg_rd && sel_data;
  wire data_wr = reg_wr && sel_data;
  wire sc_rd = reg_rd && sel_sc;
  wire is_master = block_enable && master_mode;
  wire is_slave = block_enable && !master_mode;
  wire rx_accept = shift_done && (!receive_full_flag || data_rd);
  wire rx_overrun = shift_done && receive_full_flag && !data_rd;
  // only an enabled block with a byte waiting in the buffer and an idle shifter allows a load
  wire tx_load_now = block_enable && !transmit_empty_flag && !xfer_active;
  wire slave_fault = is_slave && xfer_active && ss_n_in && !ss_n_prev;
  wire master_fault = is_master && !ss_n_in;
  wire fault_set = fault_detect_enable && (slave_fault || master_fault);
  wire [7:0] divisor = rate_divisor({rate_select_hi, rate_select_lo});
  wire [7:0] status_byte;

  assign status_byte = {receive_full_flag, error_irq_enable, overrun_flag, mode_fault_flag,
    transmit_empty_flag, fault_detect_enable, rate_select_hi, rate_select_lo};

  function [7:0] rate_divisor;
    input [1:0] code;
    begin
      case (code)
        2'h0: rate_divisor = `SSFD_DIV_00;
        2'h1: rate_divisor = `SSFD_DIV_01;
        2'h2: rate_divisor = `SSFD_DIV_10;
        default: rate_divisor = `SSFD_DIV_11;
      endcase
    end
  endfunction

  // one decoder shared by all three register addresses
  function reg_hit;
    input [15:0] addr;
    input [15:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // control bits
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_irq_enable <= 1'b0;
      master_mode <= 1'b1;
      block_enable <= 1'b0;
      tx_irq_enable <= 1'b0;
    end
    else if (reg_wr && sel_ctl)
    begin
      rx_irq_enable <= reg_wdata[`SSFD_CTL_RX_IRQ_EN];
      master_mode <= reg_wdata[`SSFD_CTL_MASTER];
      block_enable <= reg_wdata[`SSFD_CTL_ENABLE];
      tx_irq_enable <= reg_wdata[`SSFD_CTL_TX_IRQ_EN];
    end
  end

  // status-control writable bits; flag bits in this byte are not writable
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      error_irq_enable <= 1'b0;
      fault_detect_enable <= 1'b0;
      rate_select_hi <= 1'b0;
      rate_select_lo <= 1'b0;
    end
    else if (reg_wr && sel_sc)
    begin
      error_irq_enable <= reg_wdata[`SSFD_SC_ERR_IRQ_EN];
      fault_detect_enable <= reg_wdata[`SSFD_SC_FAULT_EN];
      rate_select_hi <= reg_wdata[`SSFD_SC_RATE_HI];
      rate_select_lo <= reg_wdata[`SSFD_SC_RATE_LO];
    end
  end

  // receive flags: a new byte in the same cycle as the read wins
  always @*
  begin
    next_receive_full_flag = receive_full_flag;
    next_overrun_flag = overrun_flag;
    next_ovr_armed = ovr_armed;
    if (rx_accept)
      next_receive_full_flag = 1'b1;
    else if (data_rd)
      next_receive_full_flag = 1'b0;
    if (rx_overrun)
      next_overrun_flag = 1'b1;
    else if (data_rd && ovr_armed)
      next_overrun_flag = 1'b0;
    if (sc_rd)
      next_ovr_armed = overrun_flag;
    else if (data_rd)
      next_ovr_armed = 1'b0;
  end

  // receive path and its flags
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      receive_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      ovr_armed <= 1'b0;
    end
    else
    begin
      receive_full_flag <= next_receive_full_flag;
      overrun_flag <= next_overrun_flag;
      ovr_armed <= next_ovr_armed;
    end
  end

  // receive buffer content is undefined after reset, so no reset here
  always @(posedge clk)
  begin
    if (rx_accept)
      rx_buffer <= shift_rx_byte;
  end

  // mode fault: a fault in the clearing cycle wins over the clear
  always @*
  begin
    next_mode_fault_flag = mode_fault_flag;
    next_mode_fault_flag_armed = mode_fault_flag_armed;
    if (fault_set)
      next_mode_fault_flag = 1'b1;
    else if (data_wr && mode_fault_flag_armed)
      next_mode_fault_flag = 1'b0;
    if (sc_rd)
      next_mode_fault_flag_armed = mode_fault_flag;
    else if (data_wr)
      next_mode_fault_flag_armed = 1'b0;
  end

  // mode fault
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_fault_flag <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
      ss_n_prev <= 1'b1;
    end
    else
    begin
      ss_n_prev <= ss_n_in;
      mode_fault_flag <= next_mode_fault_flag;
      mode_fault_flag_armed <= next_mode_fault_flag_armed;
    end
  end

  // a write racing a load leaves a new byte pending
  always @*
  begin
    next_transmit_empty_flag = transmit_empty_flag;
    if (data_wr)
      next_transmit_empty_flag = 1'b0;
    else if (tx_load_now)
      next_transmit_empty_flag = 1'b1;
  end

  // transmit buffer handoff
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transmit_empty_flag <= 1'b1;
      shift_load <= 1'b0;
      shift_tx_byte <= 8'h00;
    end
    else
    begin
      shift_load <= tx_load_now;
      if (tx_load_now)
        shift_tx_byte <= tx_buffer;
      transmit_empty_flag <= next_transmit_empty_flag;
    end
  end

  always @(posedge clk)
  begin
    if (data_wr)
      tx_buffer <= reg_wdata;
  end

  // half-period tick: toggling on it gives base over twice the divisor
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_count <= 8'h00;
      sck_half_tick <= 1'b0;
    end
    else if (is_master)
    begin
      if (rate_count >= divisor - 8'h01)
      begin
        rate_count <= 8'h00;
        sck_half_tick <= 1'b1;
      end
      else
      begin
        rate_count <= rate_count + 8'h01;
        sck_half_tick <= 1'b0;
      end
    end
    else
    begin
      rate_count <= 8'h00;
      sck_half_tick <= 1'b0;
    end
  end

  // slave select pin steering; the pin is driven only as general I/O
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ss_n_out <= 1'b1;
    else
      ss_n_out <= gpio_ss_out;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ss_n_oe <= 1'b0;
    else if (!block_enable || (master_mode && !fault_detect_enable))
      ss_n_oe <= gpio_ss_oe;
    else
      ss_n_oe <= 1'b0;
  end

  // a master ignoring the pin must not see it at all
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ss_n_to_engine <= 1'b1;
    else if (is_slave)
      ss_n_to_engine <= ss_n_in;
    else
      ss_n_to_engine <= 1'b1;
  end

  // requests follow the flags one cycle later, gated by their enables
  always @*
  begin
    next_rx_irq_req = receive_full_flag && rx_irq_enable;
    next_tx_irq_req = transmit_empty_flag && tx_irq_enable;
    next_err_irq_req = (overrun_flag || mode_fault_flag) && error_irq_enable;
  end

  // interrupt requests
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
      err_irq_req <= 1'b0;
    end
    else
    begin
      rx_irq_req <= next_rx_irq_req;
      tx_irq_req <= next_tx_irq_req;
      err_irq_req <= next_err_irq_req;
    end
  end

  // unread or unmapped cycles return zero so stale data never lingers
  always @*
  begin
    if (reg_rd && sel_ctl)
      next_reg_rdata = {rx_irq_enable, 1'b0, master_mode, 3'h0, block_enable, tx_irq_enable};
    else if (sc_rd)
      next_reg_rdata = status_byte;
    else if (data_rd)
      next_reg_rdata = rx_buffer;
    else
      next_reg_rdata = 8'h00;
  end

  // read data stands for exactly one cycle after the strobe
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_reg_rdata;
  end

endmodule

// File: pkg/ssfd_consts.vh
`ifndef SSFD_CONSTS_VH
`define SSFD_CONSTS_VH

// register offsets on the plain register port
`define SSFD_ADDR_W 16
`define SSFD_OFF_CONTROL 16'h0010
`define SSFD_OFF_STATUS_CONTROL 16'h0011
`define SSFD_OFF_DATA_BUFFER 16'h0012

// control register fields
`define SSFD_CTL_RX_IRQ_EN 7
`define SSFD_CTL_MASTER 5
`define SSFD_CTL_ENABLE 1
`define SSFD_CTL_TX_IRQ_EN 0
`define SSFD_CTL_WMASK 8'hA3
`define SSFD_CTL_RESET 8'h20

// status and control register fields
`define SSFD_SC_RX_FULL 7
`define SSFD_SC_ERR_IRQ_EN 6
`define SSFD_SC_OVERRUN 5
`define SSFD_SC_MODE_FAULT 4
`define SSFD_SC_TX_EMPTY 3
`define SSFD_SC_FAULT_EN 2
`define SSFD_SC_RATE_HI 1
`define SSFD_SC_RATE_LO 0

// rate divisor per rate select code
`define SSFD_DIV_00 8'h02
`define SSFD_DIV_01 8'h08
`define SSFD_DIV_10 8'h20
`define SSFD_DIV_11 8'h80

`endif

// File: sim/ssfd_monitor.sv
`timescale 1ns/10ps
module ssfd_monitor
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic xfer_active,
  input wire logic shift_load,
  input wire logic [7:0] shift_tx_byte,
  input wire logic sck_half_tick,
  input wire logic ss_n_in,
  input wire logic gpio_ss_out,
  input wire logic gpio_ss_oe,
  input wire logic ss_n_out,
  input wire logic ss_n_oe,
  input wire logic ss_n_to_engine,
  input wire logic rx_irq_req,
  input wire logic tx_irq_req,
  input wire logic err_irq_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] ctl;
  logic [7:0] sc;
  logic [7:0] lw;
  wire en_s = ctl[1] && !ctl[5];
  // shadow copies of the writable bits, tracked from the port alone
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      ctl <= 8'h20;
      sc <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 16'h0010) ctl <= reg_wdata & 8'hA3;
      if (reg_addr == 16'h0011) sc <= reg_wdata & 8'h47;
    end
  always @(posedge clk)
    if (reg_wr && reg_addr == 16'h0012) lw <= reg_wdata;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_load_waits: assert property (shift_load |-> !$past(xfer_active))
    else $error("load during transfer");
  a_load_byte: assert property (shift_load |-> shift_tx_byte == lw)
    else $error("wrong byte loaded");
  a_rx_gate: assert property (rx_irq_req |-> ctl[7] || $past(ctl[7]))
    else $error("rx request while masked");
  a_tx_gate: assert property (tx_irq_req |-> ctl[0] || $past(ctl[0]))
    else $error("tx request while masked");
  a_err_gate: assert property (err_irq_req |-> sc[6] || $past(sc[6]))
    else $error("error request while masked");
  a_fault_master: assert property (ctl[5] && ctl[1] && sc[2] && sc[6] && !ss_n_in
    |-> ##[1:3] err_irq_req) else $error("master fault missed");
  a_rate_tick: assert property (ctl[5] && ctl[1] && sc[1:0] == 2'b00 && sck_half_tick
    && !reg_wr |-> ##2 (sck_half_tick || $past(reg_wr))) else $error("tick gap");
  a_ss_engine: assert property (ss_n_to_engine == ($past(en_s) ? $past(ss_n_in) : 1'b1))
    else $error("engine select wrong");
  a_ss_gpio: assert property ($past(arst_n) |->
    ss_n_oe == $past(gpio_ss_oe && (!ctl[1] || (ctl[5] && !sc[2]))))
    else $error("select pin drive wrong");
  a_ss_out: assert property ($past(arst_n) |-> ss_n_out == $past(gpio_ss_out))
    else $error("select pin level wrong");
  c_load: cover property (shift_load);
  c_err: cover property (err_irq_req);
  c_tx: cover property (tx_irq_req);
endmodule
bind ssfd_core ssfd_monitor ssfd_monitor_inst (.*);

// File: sim/ssfd_partner.sv
`timescale 1ns/10ps
module ssfd_partner
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic shift_load,
  input wire logic [7:0] shift_tx_byte,
  output logic shift_done,
  output logic [7:0] shift_rx_byte,
  output logic xfer_active
);
  logic [2:0] cnt;
  logic [7:0] tx;
  // echo inverted so the two data buffers differ; byte wanders when not valid
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt <= 3'h0;
      xfer_active <= 1'b0;
      shift_done <= 1'b0;
      shift_rx_byte <= 8'h00;
    end
    else
    begin
      shift_done <= 1'b0;
      shift_rx_byte <= shift_rx_byte + 8'h5B;
      if (shift_load)
      begin
        xfer_active <= 1'b1;
        cnt <= 3'h5;
        tx <= shift_tx_byte;
      end
      else if (xfer_active)
      begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1)
        begin
          xfer_active <= 1'b0;
          shift_done <= 1'b1;
          shift_rx_byte <= ~tx;
        end
      end
    end
endmodule

// File: sim/ssfd_core_test.sv
`timescale 1ns/10ps
module ssfd_core_test;
  logic clk = 0;
  logic arst_n = 0;
  logic [15:0] a = 0;
  logic [7:0] wd = 0;
  logic wr = 0;
  logic rd = 0;
  logic ss_n = 1;
  logic oe = 0;
  wire [7:0] rdata;
  wire [7:0] txb;
  wire [7:0] rxb;
  wire done, act, load, tick, so, soe, se, rq, tq, eq;
  int mismatches = 0;
  int check_count = 0;
  int i;
  always #50 clk = ~clk;
  always @(posedge clk) oe <= ~oe;
  ssfd_core ssfd_core_inst (.clk(clk), .arst_n(arst_n), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .shift_done(done), .shift_rx_byte(rxb),
    .xfer_active(act), .shift_load(load), .shift_tx_byte(txb), .sck_half_tick(tick),
    .ss_n_in(ss_n), .gpio_ss_out(oe), .gpio_ss_oe(oe), .ss_n_out(so), .ss_n_oe(soe),
    .ss_n_to_engine(se), .rx_irq_req(rq), .tx_irq_req(tq), .err_irq_req(eq));
  ssfd_partner ssfd_partner_inst (.clk(clk), .arst_n(arst_n), .shift_load(load),
    .shift_tx_byte(txb), .shift_done(done), .shift_rx_byte(rxb), .xfer_active(act));
  task chk(input [7:0] seen, input [7:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wreg(input [15:0] ad, input [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input [15:0] ad, input [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, $sformatf("reg %h", ad));
  endtask
  task wdone;
    i = 0;
    while (done !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      #1 i++;
    end
    chk(i < 20, 8'h01, "done");
    // flags land one edge later, requests one more
    repeat (2) @(posedge clk);
    #1;
  endtask
  task period(input [7:0] e);
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1 n++;
      end
      while (tick !== 1'b1 && n < 300);
    end
    chk(n, e, "tick gap");
  endtask
  task ss_pulse(input v);
    @(posedge clk);
    ss_n <= v;
    @(posedge clk);
    ss_n <= ~v;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rreg(16'h0010, 8'h20);
    rreg(16'h0011, 8'h08);
    rreg(16'h0013, 8'h00);
    wreg(16'h0011, 8'hFF);
    rreg(16'h0011, 8'h4F);
    $display("test registers done");
    wreg(16'h0010, 8'h23);
    for (int c = 0; c < 4; c++)
    begin
      wreg(16'h0011, {6'h10, c[1:0]});
      period(8'h02 << (2 * c));
    end
    $display("test rate done");
    wreg(16'h0012, 8'hA5);
    rreg(16'h0011, 8'h4B);
    wdone;
    rreg(16'h0011, 8'hCB);
    chk(rq, 8'h00, "rx irq");
    chk(tq, 8'h01, "tx irq");
    wreg(16'h0010, 8'hA3);
    @(posedge clk);
    #1 chk(rq, 8'h01, "rx irq on");
    rreg(16'h0012, 8'h5A);
    rreg(16'h0011, 8'h4B);
    chk(rq, 8'h00, "rx irq off");
    wreg(16'h0012, 8'h3C);
    wdone;
    wreg(16'h0012, 8'hC3);
    wdone;
    chk(eq, 8'h01, "err irq");
    rreg(16'h0011, 8'hEB);
    rreg(16'h0012, 8'hC3);
    rreg(16'h0011, 8'h4B);
    $display("test data done");
    wreg(16'h0011, 8'h44);
    ss_pulse(1'b0);
    rreg(16'h0011, 8'h5C);
    wreg(16'h0011, 8'h40);
    rreg(16'h0011, 8'h58);
    wreg(16'h0012, 8'h66);
    wdone;
    rreg(16'h0011, 8'hC8);
    rreg(16'h0012, 8'h99);
    ss_pulse(1'b0);
    rreg(16'h0011, 8'h48);
    $display("test master fault done");
    wreg(16'h0010, 8'h03);
    ss_n <= 1'b0;
    wreg(16'h0011, 8'h44);
    wreg(16'h0012, 8'h11);
    wreg(16'h0012, 8'h22);
    ss_pulse(1'b1);
    rreg(16'h0011, 8'h54);
    wdone;
    rreg(16'h0012, 8'hEE);
    wdone;
    rreg(16'h0012, 8'hDD);
    $display("test slave done");
    finish_test;
  end
endmodule
